// *** design/two_wire_port_map.vh ***
/*
  Constants of the two-wire master/slave port: clock phase units, bus rates,
  byte layout and suggested divider values.
  Assumes a 50 MHz system clock and open-drain pads outside the block.
*/
`ifndef TWO_WIRE_PORT_MAP_VH
`define TWO_WIRE_PORT_MAP_VH

// ---------------------------------------------------------------------------
// Clock shape
// ---------------------------------------------------------------------------
`define CLOCK_LOW_PHASE_UNITS 6
`define CLOCK_HIGH_PHASE_UNITS 4
`define SYS_CLK_KHZ 50000
`define STD_RATE_KBPS 100
`define FAST_RATE_KBPS 400
// Divider = clk / (2 * (low + high) * rate) - 1, rounded up so the rate is not exceeded
`define STD_DIVIDER (((`SYS_CLK_KHZ) + 2 * 10 * (`STD_RATE_KBPS) - 1) / (2 * 10 * (`STD_RATE_KBPS)) - 1)
`define FAST_DIVIDER (((`SYS_CLK_KHZ) + 2 * 10 * (`FAST_RATE_KBPS) - 1) / (2 * 10 * (`FAST_RATE_KBPS)) - 1)

// ---------------------------------------------------------------------------
// Byte layout
// ---------------------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1

`endif

// *** design/two_wire_master_slave_port.v ***
/*
  Two-wire bus port with an independent master and slave on the same pads.
  Assumes open-drain pads: the pad pulls low while an output enable is high,
  and the pad level returns on the input pins, asynchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "two_wire_port_map.vh"

// Behaviour
// - Two open-drain lines only: serial data and serial clock; data flows both ways.
// - Port transmits and receives as master and as slave.
// - Master and slave operate at the same time, independently.
// - Divider gives standard 100 Kbps and fast 400 Kbps rates.
// - Master pulses completion interrupt on finish and on error abort.
// - Slave pulses interrupts on data written and on data requested.
// - Master and slave have separate control and status.
// - Lines are only pulled low or released, and sampled as inputs.
// - Data falling with clock high is start, rising is stop; tracks bus busy.
// - Eight-bit bytes, most significant first, then receiver acknowledge bit.
// - First byte is seven-bit address plus direction, one means read.
// - Clock period is 6 low plus 4 high units of (divider+1)*2 clocks.
module two_wire_master_slave_port #(
  parameter DIV_WIDTH = 7
) (
  input wire ref_clk,
  input wire rst,
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  input wire serialDataLineIn,
  output wire serialDataLineOut,
  output wire serialDataLineOe,
  input wire [DIV_WIDTH-1:0] sclPeriodDivider,
  input wire masterStart,
  input wire [6:0] masterAddr,
  input wire masterRead,
  input wire [7:0] masterTxData,
  output reg [7:0] masterRxData,
  output wire masterBusy,
  output reg masterDone,
  output reg masterAddrNack,
  output reg masterDataNack,
  output reg masterArbLost,
  input wire slaveEnable,
  input wire [6:0] slaveAddr,
  input wire [7:0] slaveTxData,
  output reg [7:0] slaveRxData,
  output reg slaveRxIrq,
  output reg slaveTxReqIrq,
  output wire busBusyOut
);

  // -------------------------------------------------------------------------
  // Pad synchronisers and bus condition detection
  // -------------------------------------------------------------------------
  reg scl1, sclS, sclPrev;
  reg sda1, sdaS, sdaPrev;
  reg busBusy;
  wire sclRise = sclS & ~sclPrev;
  wire sclFall = ~sclS & sclPrev;
  wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;

  always @(posedge ref_clk) begin
    if (rst) begin
      scl1 <= 1'b1;
      sclS <= 1'b1;
      sclPrev <= 1'b1;
      sda1 <= 1'b1;
      sdaS <= 1'b1;
      sdaPrev <= 1'b1;
      busBusy <= 1'b0;
    end else begin
      scl1 <= sclIn;
      sclS <= scl1;
      sclPrev <= sclS;
      sda1 <= serialDataLineIn;
      sdaS <= sda1;
      sdaPrev <= sdaS;
      if (startSeen) begin
        busBusy <= 1'b1;
      end else if (stopSeen) begin
        busBusy <= 1'b0;
      end
    end
  end
  assign busBusyOut = busBusy;

  // -------------------------------------------------------------------------
  // Open-drain pad drive
  // -------------------------------------------------------------------------
  reg mSclLow, mSdaLow, sSdaLow;
  assign sclOut = 1'b0;
  assign serialDataLineOut = 1'b0;
  assign sclOe = mSclLow;
  assign serialDataLineOe = mSdaLow | sSdaLow;

  // -------------------------------------------------------------------------
  // Master
  // -------------------------------------------------------------------------
  localparam M_IDLE = 3'd0;
  localparam M_START = 3'd1;
  localparam M_BIT = 3'd2;
  localparam M_STOP = 3'd3;
  localparam M_DONE = 3'd4;

  reg [2:0] mState;
  reg [DIV_WIDTH:0] unitCnt;
  reg [2:0] phaseCnt;
  reg highPhase;
  reg [3:0] bitCnt;
  reg byteSel;
  reg mRd;
  reg [7:0] mShift;
  reg [7:0] mTxData;

  wire [DIV_WIDTH:0] unitLimit = {sclPeriodDivider, 1'b1};
  wire stall = highPhase & ~sclS & (mState != M_START);
  wire unitTick = (unitCnt == unitLimit) & ~stall;
  wire sending = (bitCnt < `BITS_PER_BYTE) & (~byteSel | (mRd == `DIR_WRITE));
  wire ackCheck = (bitCnt == `BITS_PER_BYTE) & (~byteSel | (mRd == `DIR_WRITE));
  wire lowEnd = (phaseCnt == `CLOCK_LOW_PHASE_UNITS - 1);
  wire highEnd = (phaseCnt == `CLOCK_HIGH_PHASE_UNITS - 1);
  assign masterBusy = (mState != M_IDLE);

  always @(posedge ref_clk) begin
    if (rst) begin
      mState <= M_IDLE;
      unitCnt <= {(DIV_WIDTH+1){1'b0}};
      phaseCnt <= 3'd0;
      highPhase <= 1'b1;
      bitCnt <= 4'h0;
      byteSel <= 1'b0;
      mRd <= 1'b0;
      mShift <= 8'h00;
      mTxData <= 8'h00;
      mSclLow <= 1'b0;
      mSdaLow <= 1'b0;
      masterRxData <= 8'h00;
      masterDone <= 1'b0;
      masterAddrNack <= 1'b0;
      masterDataNack <= 1'b0;
      masterArbLost <= 1'b0;
    end else begin
      masterDone <= 1'b0;
      if (mState == M_IDLE || stall || unitTick) begin
        unitCnt <= {(DIV_WIDTH+1){1'b0}};
      end else begin
        unitCnt <= unitCnt + 1'b1;
      end
      case (mState)
        M_IDLE: begin
          if (masterStart && !busBusy) begin
            mShift <= {masterAddr, masterRead};
            mRd <= masterRead;
            mTxData <= masterTxData;
            masterAddrNack <= 1'b0;
            masterDataNack <= 1'b0;
            masterArbLost <= 1'b0;
            mSdaLow <= 1'b1;
            highPhase <= 1'b1;
            phaseCnt <= 3'd0;
            mState <= M_START;
          end
        end
        M_START: begin
          if (unitTick) begin
            if (highEnd) begin
              mSclLow <= 1'b1;
              highPhase <= 1'b0;
              phaseCnt <= 3'd0;
              bitCnt <= 4'h0;
              byteSel <= 1'b0;
              mState <= M_BIT;
            end else begin
              phaseCnt <= phaseCnt + 3'd1;
            end
          end
        end
        M_BIT: begin
          if (unitTick && !highPhase) begin
            if (phaseCnt == 3'd0) begin
              mSdaLow <= sending & ~mShift[7];
            end
            if (lowEnd) begin
              mSclLow <= 1'b0;
              highPhase <= 1'b1;
              phaseCnt <= 3'd0;
            end else begin
              phaseCnt <= phaseCnt + 3'd1;
            end
          end else if (unitTick) begin
            if (phaseCnt == 3'd0) begin
              if (bitCnt < `BITS_PER_BYTE) begin
                mShift <= {mShift[6:0], sdaS};
              end
              if (sending && !mSdaLow && !sdaS) begin
                masterArbLost <= 1'b1;
                mSdaLow <= 1'b0;
                mState <= M_DONE;
              end
              if (ackCheck && sdaS) begin
                if (byteSel) begin
                  masterDataNack <= 1'b1;
                end else begin
                  masterAddrNack <= 1'b1;
                end
              end
            end
            if (highEnd) begin
              mSclLow <= 1'b1;
              highPhase <= 1'b0;
              phaseCnt <= 3'd0;
              if (bitCnt == `BITS_PER_BYTE) begin
                bitCnt <= 4'h0;
                if (byteSel || masterAddrNack) begin
                  masterRxData <= mShift;
                  mState <= M_STOP;
                end else begin
                  byteSel <= 1'b1;
                  mShift <= mTxData;
                end
              end else begin
                bitCnt <= bitCnt + 4'h1;
              end
            end else begin
              phaseCnt <= phaseCnt + 3'd1;
            end
          end
        end
        M_STOP: begin
          if (unitTick && !highPhase) begin
            if (phaseCnt == 3'd0) begin
              mSdaLow <= 1'b1;
            end
            if (lowEnd) begin
              mSclLow <= 1'b0;
              highPhase <= 1'b1;
              phaseCnt <= 3'd0;
            end else begin
              phaseCnt <= phaseCnt + 3'd1;
            end
          end else if (unitTick) begin
            if (highEnd) begin
              mSdaLow <= 1'b0;
              mState <= M_DONE;
            end else begin
              phaseCnt <= phaseCnt + 3'd1;
            end
          end
        end
        M_DONE: begin
          mSclLow <= 1'b0;
          highPhase <= 1'b1;
          phaseCnt <= 3'd0;
          masterDone <= 1'b1;
          mState <= M_IDLE;
        end
        default: begin
          mState <= M_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Slave
  // -------------------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ADDR_ACK = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_RX_ACK = 3'd4;
  localparam S_TX = 3'd5;
  localparam S_TX_ACK = 3'd6;

  reg [2:0] sState;
  reg [3:0] sCnt;
  reg [7:0] sShift;
  reg [7:0] sTx;
  reg sAcked;

  always @(posedge ref_clk) begin
    if (rst) begin
      sState <= S_IDLE;
      sCnt <= 4'h0;
      sShift <= 8'h00;
      sTx <= 8'h00;
      sAcked <= 1'b0;
      sSdaLow <= 1'b0;
      slaveRxData <= 8'h00;
      slaveRxIrq <= 1'b0;
      slaveTxReqIrq <= 1'b0;
    end else begin
      slaveRxIrq <= 1'b0;
      slaveTxReqIrq <= 1'b0;
      if (startSeen) begin
        sSdaLow <= 1'b0;
        sCnt <= 4'h0;
        sState <= slaveEnable ? S_ADDR : S_IDLE;
      end else if (stopSeen) begin
        sSdaLow <= 1'b0;
        sState <= S_IDLE;
      end else begin
        case (sState)
          S_ADDR, S_RX: begin
            if (sclRise) begin
              sShift <= {sShift[6:0], sdaS};
              sCnt <= sCnt + 4'h1;
            end else if (sclFall && sCnt == `BITS_PER_BYTE) begin
              if (sState == S_RX) begin
                sSdaLow <= 1'b1;
                slaveRxData <= sShift;
                slaveRxIrq <= 1'b1;
                sState <= S_RX_ACK;
              end else if (sShift[7:1] == slaveAddr) begin
                sSdaLow <= 1'b1;
                slaveTxReqIrq <= (sShift[0] == `DIR_READ);
                sState <= S_ADDR_ACK;
              end else begin
                sState <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK, S_RX_ACK: begin
            if (sclFall) begin
              sCnt <= 4'h0;
              if (sState == S_ADDR_ACK && sShift[0] == `DIR_READ) begin
                sSdaLow <= ~slaveTxData[7];
                sTx <= {slaveTxData[6:0], 1'b0};
                sCnt <= 4'h1;
                sState <= S_TX;
              end else begin
                sSdaLow <= 1'b0;
                sState <= S_RX;
              end
            end
          end
          S_TX: begin
            if (sclFall) begin
              if (sCnt == `BITS_PER_BYTE) begin
                sSdaLow <= 1'b0;
                sState <= S_TX_ACK;
              end else begin
                sSdaLow <= ~sTx[7];
                sTx <= {sTx[6:0], 1'b0};
                sCnt <= sCnt + 4'h1;
              end
            end
          end
          S_TX_ACK: begin
            if (sclRise) begin
              sAcked <= ~sdaS;
              slaveTxReqIrq <= ~sdaS;
            end else if (sclFall) begin
              if (sAcked) begin
                sSdaLow <= ~slaveTxData[7];
                sTx <= {slaveTxData[6:0], 1'b0};
                sCnt <= 4'h1;
                sState <= S_TX;
              end else begin
                sState <= S_IDLE;
              end
            end
          end
          default: begin
            sSdaLow <= 1'b0;
            sState <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // two_wire_master_slave_port

// *** test/two_wire_port_properties.sv ***
/* Checker on the two-wire port top module ports.
   Assumes bind from the bench top file and a divider held steady per transfer. */
`timescale 1ns/100ps
module two_wire_port_properties #(
  parameter DIV_WIDTH = 7
) (
  input wire ref_clk,
  input wire rst,
  input wire sclIn,
  input wire sclOut,
  input wire sclOe,
  input wire serialDataLineIn,
  input wire serialDataLineOut,
  input wire [DIV_WIDTH-1:0] sclPeriodDivider,
  input wire masterStart,
  input wire masterBusy,
  input wire masterDone,
  input wire masterAddrNack,
  input wire masterDataNack,
  input wire busBusyOut,
  input wire slaveEnable,
  input wire slaveRxIrq,
  input wire slaveTxReqIrq
);
  // ---------------------------------------------
  // Phase counters
  // ---------------------------------------------
  reg [15:0] hiCnt;
  reg [15:0] loCnt;
  wire [15:0] unitClk;
  assign unitClk = (sclPeriodDivider + 16'h0001) << 1;
  always @(posedge ref_clk) begin
    if (rst) begin
      hiCnt <= 16'h0000;
      loCnt <= 16'h0000;
    end else begin
      hiCnt <= sclOe ? hiCnt + 16'h0001 : 16'h0000;
      loCnt <= (sclOe || loCnt == 16'hFFFF) ? {16{!sclOe}} : loCnt + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_start_cond;
    $fell(serialDataLineIn) && sclIn && $past(sclIn);
  endsequence
  sequence s_stop_cond;
    $rose(serialDataLineIn) && sclIn && $past(sclIn);
  endsequence
  a_done_pulse: assert property (masterDone |=> !masterDone)
    else $error("done pulse too long");
  a_done_idle: assert property (masterDone |-> ##[1:2] !masterBusy)
    else $error("busy after done");
  a_start_free: assert property ($rose(masterBusy) |-> $past(masterStart) && !$past(busBusyOut))
    else $error("start taken on busy bus");
  a_flags_clear: assert property ($rose(masterBusy) |-> !masterAddrNack && !masterDataNack)
    else $error("status not cleared");
  a_low_phase: assert property ($fell(sclOe) |-> hiCnt == 16'h0006 * unitClk)
    else $error("clock low phase length");
  a_high_phase: assert property ($rose(sclOe) |-> loCnt >= 16'h0004 * unitClk)
    else $error("clock high phase short");
  a_clock_owner: assert property (!masterBusy |-> !sclOe)
    else $error("clock driven while idle");
  a_open_drain: assert property (sclOut == 1'b0 && serialDataLineOut == 1'b0)
    else $error("pad value not low");
  a_busy_start: assert property (s_start_cond |-> ##[1:6] busBusyOut)
    else $error("start not seen");
  a_free_stop: assert property (s_stop_cond |-> ##[1:6] !busBusyOut)
    else $error("stop not seen");
  a_rx_pulse: assert property (slaveRxIrq |=> !slaveRxIrq)
    else $error("slave irq too long");
  a_slave_quiet: assert property (!slaveEnable |-> !slaveRxIrq && !slaveTxReqIrq)
    else $error("disabled slave irq");
endmodule // two_wire_port_properties

// *** test/two_wire_ext_slave.sv ***
/* External slave model: acks its address, takes one written byte, sends one byte.
   Assumes wire levels with pull-ups on both lines. */
`timescale 1ns/100ps
module two_wire_ext_slave #(
  parameter [6:0] OWN_ADDR = 7'h3C
) (
  input wire scl,
  input wire sda,
  input wire [7:0] txByte,
  output reg sdaOe,
  output reg [7:0] rxByte
);
  // ---------------------------------------------
  // Bus follower
  // ---------------------------------------------
  reg [7:0] sh;
  integer i;
  task drv(input reg v);
    begin
      #45 sdaOe = v;
    end
  endtask
  task shift8;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
  endtask
  initial begin
    sdaOe = 1'b0;
    rxByte = 8'h00;
    sh = 8'h00;
    forever begin
      @(negedge sda);
      if (scl === 1'b1) begin
        shift8;
        @(negedge scl);
        if (sh[7:1] == OWN_ADDR) begin
          drv(1'b1);
          @(negedge scl);
          if (sh[0]) begin
            for (i = 7; i >= 0; i = i - 1) begin
              drv(~txByte[i]);
              @(negedge scl);
            end
            drv(1'b0);
          end else begin
            drv(1'b0);
            shift8;
            rxByte = sh;
            @(negedge scl);
            drv(1'b1);
            @(negedge scl);
            drv(1'b0);
          end
        end
      end
    end
  end
endmodule // two_wire_ext_slave

// *** test/two_wire_master_slave_port_tb.sv ***
/* Bench: master transfers to an external slave, to the own slave, to nobody.
   Assumes pull-ups on both lines and a 50 MHz clock. */
`timescale 1ns/100ps
`include "two_wire_port_map.vh"
module two_wire_master_slave_port_tb;
  // ---------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------
  reg ref_clk, rst, masterStart, masterRead, slaveEnable, rxSeen, txReqSeen, jam, jamMode;
  reg [6:0] sclPeriodDivider, masterAddr;
  reg [7:0] masterTxData, slaveTxData, extTx, rxVal;
  wire sclOe, sclOut, serialDataLineOut, serialDataLineOe, extOe, masterBusy, masterDone;
  wire masterAddrNack, masterDataNack, masterArbLost, slaveRxIrq, slaveTxReqIrq, busBusyOut;
  wire [7:0] masterRxData, slaveRxData, extRx;
  wire sclWire = ~sclOe;
  wire sdaWire = ~(serialDataLineOe | extOe | jam);
  integer errTotal, compares, cyc, n;
  two_wire_master_slave_port i_dut (.ref_clk(ref_clk), .rst(rst), .sclIn(sclWire), .sclOut(sclOut),
    .sclOe(sclOe), .serialDataLineIn(sdaWire), .serialDataLineOut(serialDataLineOut),
    .serialDataLineOe(serialDataLineOe), .sclPeriodDivider(sclPeriodDivider), .masterStart(masterStart),
    .masterAddr(masterAddr), .masterRead(masterRead), .masterTxData(masterTxData),
    .masterRxData(masterRxData), .masterBusy(masterBusy), .masterDone(masterDone),
    .masterAddrNack(masterAddrNack), .masterDataNack(masterDataNack), .masterArbLost(masterArbLost),
    .slaveEnable(slaveEnable), .slaveAddr(7'h52), .slaveTxData(slaveTxData), .slaveRxData(slaveRxData),
    .slaveRxIrq(slaveRxIrq), .slaveTxReqIrq(slaveTxReqIrq), .busBusyOut(busBusyOut));
  two_wire_ext_slave #(.OWN_ADDR(7'h3C)) i_ext (.scl(sclWire), .sda(sdaWire), .txByte(extTx),
    .sdaOe(extOe), .rxByte(extRx));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (slaveRxIrq === 1'b1) rxVal <= slaveRxData;
    rxSeen <= (rxSeen & ~masterStart) | (slaveRxIrq === 1'b1);
    txReqSeen <= (txReqSeen & ~masterStart) | (slaveTxReqIrq === 1'b1);
    if (cyc == 80000) begin
      errTotal = errTotal + 1;
      close_out;
    end
  end
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  function [6:0] addrOf(input integer t);
    addrOf = (t == 0) ? 7'h3C : (t == 1) ? 7'h52 : 7'h11;
  endfunction
  function acks(input integer t, input en);
    acks = (t == 0) || (t == 1 && en);
  endfunction
  task run(input integer t, input rd, input en);
    reg [7:0] d;
    reg ack;
    integer k;
    begin
      d = $urandom;
      if (jamMode) d[7] = 1'b1;
      ack = acks(t, en);
      slaveEnable <= en;
      extTx <= $urandom;
      slaveTxData <= $urandom;
      masterAddr <= addrOf(t);
      masterRead <= rd;
      masterTxData <= d;
      masterStart <= 1'b1;
      k = 0;
      do begin @(negedge ref_clk); k = k + 1; end while (masterBusy !== 1'b1 && k < 100);
      @(posedge ref_clk);
      masterStart <= 1'b0;
      if (jamMode) begin
        repeat (10) @(negedge sclWire);
        @(posedge ref_clk);
        jam <= 1'b1;
      end
      k = 0;
      do begin @(negedge ref_clk); k = k + 1; end while (masterDone !== 1'b1 && k < 20000);
      chk("done", 8'h01, masterDone);
      if (jamMode) begin
        @(posedge ref_clk);
        jam <= 1'b0;
      end
      repeat (10) @(negedge ref_clk);
      chk("addr nack", !ack, masterAddrNack);
      chk("data nack", 8'h00, masterDataNack);
      chk("arb lost", jamMode, masterArbLost);
      if (ack && rd) chk("read byte", (t == 0) ? extTx : slaveTxData, masterRxData);
      if (ack && !rd && !jamMode) chk("written byte", d, (t == 0) ? extRx : rxVal);
      chk("slave rx irq", t == 1 && ack && !rd && !jamMode, rxSeen);
      chk("slave read irq", t == 1 && ack && rd, txReqSeen);
      $display("test addr %h read %0d done", addrOf(t), rd);
      @(posedge ref_clk);
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    errTotal = 0;
    compares = 0;
    cyc = 0;
    rst = 1'b1;
    {masterStart, masterRead, rxSeen, txReqSeen, jam, jamMode} = 6'h00;
    {masterAddr, masterTxData, slaveTxData, extTx, rxVal} = 39'h0;
    sclPeriodDivider = `STD_DIVIDER;
    slaveEnable = 1'b1;
    n = $urandom(70);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("bus busy", 8'h00, busBusyOut);
    repeat (3) @(posedge ref_clk);
    run(0, 1'b0, 1'b1);
    sclPeriodDivider <= `FAST_DIVIDER;
    run(0, 1'b1, 1'b1);
    run(1, 1'b0, 1'b1);
    run(1, 1'b1, 1'b1);
    run(2, 1'b0, 1'b1);
    run(1, 1'b1, 1'b0);
    jamMode = 1'b1;
    run(1, 1'b0, 1'b1);
    jamMode = 1'b0;
    for (n = 0; n < 12; n = n + 1) begin
      sclPeriodDivider <= $urandom % 3;
      run($urandom % 3, $urandom % 2, $urandom % 2);
    end
    close_out;
  end
endmodule // two_wire_master_slave_port_tb
bind two_wire_master_slave_port two_wire_port_properties #(.DIV_WIDTH(DIV_WIDTH)) i_props (
  .ref_clk(ref_clk), .rst(rst), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .serialDataLineIn(serialDataLineIn), .serialDataLineOut(serialDataLineOut),
  .sclPeriodDivider(sclPeriodDivider), .masterStart(masterStart), .masterBusy(masterBusy),
  .masterDone(masterDone), .masterAddrNack(masterAddrNack), .masterDataNack(masterDataNack),
  .busBusyOut(busBusyOut), .slaveEnable(slaveEnable), .slaveRxIrq(slaveRxIrq), .slaveTxReqIrq(slaveTxReqIrq));
